/* File: enph_defs.vh */
// Purpose : shared constants of the next-protocol header stage
// Assumes : included by bare name from every design file of the stage
// Notes   : offsets are byte addresses on the apb register port
`ifndef ENPH_DEFS_VH
`define ENPH_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ENPH_OFS_CTRL      8'h00
`define ENPH_OFS_TYPE      8'h04
`define ENPH_OFS_TPID      8'h08
`define ENPH_OFS_STATUS    8'h0C

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ENPH_CTRL_TCE      0
`define ENPH_CTRL_BBE      1
`define ENPH_CTRL_MODE     2
`define ENPH_CTRL_NXT_LO   4
`define ENPH_CTRL_NXT_HI   6
`define ENPH_CTRL_SIG_LO   8
`define ENPH_CTRL_SIG_HI   12

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ENPH_RST_NXT       3'h5
`define ENPH_RST_SIG       5'h00
`define ENPH_RST_TYPE      16'h0000
`define ENPH_RST_MASK      16'hffff
`define ENPH_RST_TPID      16'h8a88

// ------------------------------------------------------------
// comparator stage identifiers
// ------------------------------------------------------------
// codes for the next-stage pointer
`define ENPH_ID_ETH1       3'h0
`define ENPH_ID_ETH2       3'h1
`define ENPH_ID_IP1        3'h2
`define ENPH_ID_IP2        3'h3
`define ENPH_ID_MPLS       3'h4
`define ENPH_ID_PTP        3'h5

// ------------------------------------------------------------
// protocol values
// ------------------------------------------------------------
`define ENPH_TPID_CTAG     16'h8100
`define ENPH_TPID_ITAG     16'h88e7
`define ENPH_LEN_LIMIT     16'h0600
`define ENPH_SAP_A         8'haa
`define ENPH_SAP_B         8'hab
`define ENPH_LLC_CTL       8'h03
`define ENPH_OUI_ALT       8'hf8

// ------------------------------------------------------------
// field lengths in bytes, minus one
// ------------------------------------------------------------
`define ENPH_ADDR_LAST     4'hb
`define ENPH_ITAG_LAST     4'h3
`define ENPH_LLC_LAST      4'h5

`endif

/* File: enph_snap_check.v */
// Purpose : checks one byte of the llc header and snap oui
// Assumes : idx counts from the dsap octet, 0..5
// Notes   : the oui values are fixed in hardware
`include "enph_defs.vh"

module enph_snap_check (
   input  wire [3:0] idx,
   input  wire [7:0] data,
   output reg        byte_ok
);

   always @* begin
      case (idx)
         4'h0, 4'h1: byte_ok = (data == `ENPH_SAP_A) || (data == `ENPH_SAP_B);
         4'h2:       byte_ok = (data == `ENPH_LLC_CTL);
         4'h3, 4'h4: byte_ok = (data == 8'h00);
         4'h5:       byte_ok = (data == 8'h00) || (data == `ENPH_OUI_ALT);
         default:    byte_ok = 1'b0;
      endcase
   end

endmodule // enph_snap_check

/* File: enph_src_model.sv */
// Purpose : header byte source and flow half beside the stage
// Assumes : send is called right after a rising edge
// Notes   : idle byte lines show the inverse of the last byte
module enph_src_model (
   input  wire logic       pclk,
   output logic            frame_valid,
   output logic            frame_start,
   output logic            frame_last,
   output logic [7:0]      frame_byte,
   output logic            flow_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_valid = 1'b0;
      frame_start = 1'b0;
      frame_last = 1'b0;
      frame_byte = 8'h00;
      flow_hit = 1'b0;
   end
   task automatic send(input logic [7:0] f[$], input bit slow, input bit hit);
      foreach (f[i]) begin
         frame_valid <= 1'b1;
         frame_start <= (i == 0);
         frame_last <= (i == f.size() - 1);
         frame_byte <= f[i];
         flow_hit <= hit;
         @(posedge pclk);
         if (slow || i == f.size() - 1) begin
            frame_valid <= 1'b0;
            frame_byte <= ~f[i];
            if (slow) @(posedge pclk);
         end
      end
   endtask
endmodule // enph_src_model

/* File: enph_stage.v */
// Purpose : ethernet/llc/snap next-protocol stage of an analyzer engine
// Assumes : one header byte per valid cycle, byte 0 marked by frame_start
// Notes   : flow matching itself arrives on flow_hit from the flow half
//
// Operation
// - two ethernet stages per engine; first fixed first, second anywhere
// - accept length frames with plain type, llc, or llc plus snap; here a length frame matches only with llc plus snap
// - type ii takes up to two tags, s-tag or c-tag 0x8100
// - next header starts on byte after the final type field
// - snap only after llc with saps aa/ab and control 03
// - snap is three oui octets then a two-octet type
// - snap oui must be zero or 0xf8, not programmable
// - vlan type inside snap makes a tag parse before next protocol
// - two tags plus llc plus snap is the longest header
// - backbone frames use both ethernet stages back to back
// - backbone mode: type ii, zero or one b-tag, then i-tag
// - next-protocol check uses one register set for all flows
// - flow comparison done separately, any configured flow may match
// - check last type field, tags and length, with pattern and offset
// - 3-bit field selects next comparator stage
// - 5-bit field gives frame signature field position
// - one 16-bit tpid recognises s-tags, b-tags and other tags
// - backbone enable exists only in first stage
// - type compare only for type ii frames when enabled
// - stage ids 0,1 ethernet, 2,3 ip, 4 mpls, 5 ptp/oam
// - offset counts bytes from header start, first byte zero
// - mask bit one compares, mask bit zero is wildcard
// - below 0x0600 is length needing llc/snap, else no llc allowed
//
// Design decisions made here: the placing of the registers and the APB slave port.
`include "enph_defs.vh"

module enph_stage #(
   parameter [2:0] STAGE_ID = `ENPH_ID_ETH1
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        frame_valid,
   input  wire        frame_start,
   input  wire        frame_last,
   input  wire [7:0]  frame_byte,
   input  wire        flow_hit,
   output reg         res_valid,
   output reg         res_match,
   output reg  [2:0]  res_next_stage,
   output reg  [5:0]  res_offset,
   output reg  [4:0]  res_sig_offset
);

   // ------------------------------------------------------------
   // parser states
   // ------------------------------------------------------------
   localparam [6:0] S_IDLE = 7'b000_0001;
   localparam [6:0] S_ADDR = 7'b000_0010;
   localparam [6:0] S_TYPE = 7'b000_0100;
   localparam [6:0] S_TAG  = 7'b000_1000;
   localparam [6:0] S_ITAG = 7'b001_0000;
   localparam [6:0] S_LLC  = 7'b010_0000;
   localparam [6:0] S_WAIT = 7'b100_0000;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   reg        type_compare_enable;
   reg        backbone_bridging_enable;
   reg        type_mode;
   reg [2:0]  next_stage_pointer;
   reg [4:0]  signature_field_position;
   reg [15:0] type_compare_value;
   reg [15:0] type_compare_mask;
   reg [15:0] service_tag_protocol_id;

   // ------------------------------------------------------------
   // parser state
   // ------------------------------------------------------------
   reg [6:0]  state;
   reg [5:0]  off;
   reg [3:0]  sub;
   reg [1:0]  tags;
   reg        llc_seen;
   reg [7:0]  type_hi;
   reg        last_match;
   reg [5:0]  last_offset;

   wire [15:0] type_now = {type_hi, frame_byte};
   wire        is_ctag;
   wire        is_stag;
   wire        is_itag;
   wire        is_len;
   wire        llc_ok;
   wire        bb_active;
   wire        type_hit;
   wire        setup;
   wire        access;
   wire        hit_ctrl;
   wire        hit_type;
   wire        hit_tpid;
   wire        hit_stat;
   wire        mapped;

   enph_tag_class u_class (
      .type_field              (type_now),
      .service_tag_protocol_id (service_tag_protocol_id),
      .is_ctag                 (is_ctag),
      .is_stag                 (is_stag),
      .is_itag                 (is_itag),
      .is_len                  (is_len)
   );

   enph_snap_check u_snap (
      .idx     (sub),
      .data    (frame_byte),
      .byte_ok (llc_ok)
   );

   assign bb_active = backbone_bridging_enable && (STAGE_ID == `ENPH_ID_ETH1);

   assign type_hit = ((type_now ^ type_compare_value) & type_compare_mask) == 16'h0000;

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign setup    = psel && !penable;
   assign access   = psel && penable && pready;
   assign hit_ctrl = (paddr == `ENPH_OFS_CTRL);
   assign hit_type = (paddr == `ENPH_OFS_TYPE);
   assign hit_tpid = (paddr == `ENPH_OFS_TPID);
   assign hit_stat = (paddr == `ENPH_OFS_STATUS);
   assign mapped   = hit_ctrl || hit_type || hit_tpid || hit_stat;

   // ready is raised in setup so every access closes in one access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && (!mapped || (pwrite && hit_stat));
         if (setup && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_ctrl) begin
               prdata[`ENPH_CTRL_TCE]                   <= type_compare_enable;
               prdata[`ENPH_CTRL_BBE]                   <= bb_active;
               prdata[`ENPH_CTRL_MODE]                  <= type_mode;
               prdata[`ENPH_CTRL_NXT_HI:`ENPH_CTRL_NXT_LO] <= next_stage_pointer;
               prdata[`ENPH_CTRL_SIG_HI:`ENPH_CTRL_SIG_LO] <= signature_field_position;
            end
            if (hit_type) begin
               prdata <= {type_compare_mask, type_compare_value};
            end
            if (hit_tpid) begin
               prdata[15:0] <= service_tag_protocol_id;
            end
            if (hit_stat) begin
               prdata[0]    <= last_match;
               prdata[1]    <= (state != S_IDLE);
               prdata[13:8] <= last_offset;
            end
         end
      end
   end

   // single register set for all flows
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         type_compare_enable      <= 1'b0;
         backbone_bridging_enable <= 1'b0;
         type_mode                <= 1'b0;
         next_stage_pointer       <= `ENPH_RST_NXT;
         signature_field_position <= `ENPH_RST_SIG;
         type_compare_value       <= `ENPH_RST_TYPE;
         type_compare_mask        <= `ENPH_RST_MASK;
         service_tag_protocol_id  <= `ENPH_RST_TPID;
      end else if (access && pwrite) begin
         if (hit_ctrl) begin
            type_compare_enable      <= pwdata[`ENPH_CTRL_TCE];
            // bit is held clear in the second stage
            backbone_bridging_enable <= pwdata[`ENPH_CTRL_BBE] &&
                                        (STAGE_ID == `ENPH_ID_ETH1);
            type_mode                <= pwdata[`ENPH_CTRL_MODE];
            next_stage_pointer       <= pwdata[`ENPH_CTRL_NXT_HI:`ENPH_CTRL_NXT_LO];
            signature_field_position <= pwdata[`ENPH_CTRL_SIG_HI:`ENPH_CTRL_SIG_LO];
         end
         if (hit_type) begin
            type_compare_value <= pwdata[15:0];
            type_compare_mask  <= pwdata[31:16];
         end
         if (hit_tpid) begin
            service_tag_protocol_id <= pwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // header parser
   // ------------------------------------------------------------
   // decision at the second byte of a type/length field
   reg [6:0] next_state;
   reg       next_done;
   reg       next_ok;

   always @* begin
      next_state = S_TYPE;
      next_done  = 1'b0;
      next_ok    = 1'b0;
      if (bb_active) begin
         if (is_itag) begin
            next_state = S_ITAG;
         end else if (is_stag && (tags == 2'd0)) begin
            next_state = S_TAG;
         end else begin
            next_done = 1'b1;
         end
      // up to two s- or c-tags
      end else if ((is_ctag || is_stag) && (tags != 2'd2)) begin
         next_state = S_TAG;
      end else if (is_len) begin
         if (llc_seen || !type_mode) begin
            next_done = 1'b1;
         end else begin
            next_state = S_LLC;
         end
      end else begin
         next_done = 1'b1;
         // compare only for type ii frames
         next_ok   = !type_compare_enable || llc_seen || type_hit;
      end
   end

   // result on the byte that closes the final type
   wire fire_type = (state == S_TYPE) && (sub == 4'h1) && next_done;
   // i-tag end hands the customer header on
   wire fire_itag = (state == S_ITAG) && (sub == `ENPH_ITAG_LAST);
   // bad llc or oui byte, or frame cut inside the header
   wire fire_fail = ((state == S_LLC) && !llc_ok) || (frame_last && !state[0] && !state[6]);
   wire fire      = fire_type || fire_itag || fire_fail;
   // flow result joins the protocol result
   wire fire_hit  = flow_hit && (fire_itag || (fire_type && next_ok));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= S_IDLE;
         off            <= 6'd0;
         sub            <= 4'h0;
         tags           <= 2'd0;
         llc_seen       <= 1'b0;
         type_hi        <= 8'h00;
         res_valid      <= 1'b0;
         res_match      <= 1'b0;
         res_next_stage <= `ENPH_RST_NXT;
         res_offset     <= 6'd0;
         res_sig_offset <= `ENPH_RST_SIG;
         last_match     <= 1'b0;
         last_offset    <= 6'd0;
      end else begin
         res_valid <= 1'b0;
         if (frame_valid) begin
            off <= off + 6'd1;
            case (state)
               S_IDLE: begin
                  // byte 0 is the first header byte
                  if (frame_start) begin
                     off      <= 6'd1;
                     sub      <= 4'h1;
                     tags     <= 2'd0;
                     llc_seen <= 1'b0;
                     state    <= S_ADDR;
                  end
               end
               S_ADDR: begin
                  sub <= sub + 4'h1;
                  if (sub == `ENPH_ADDR_LAST) begin
                     sub   <= 4'h0;
                     state <= S_TYPE;
                  end
               end
               S_TYPE: begin
                  if (sub == 4'h0) begin
                     type_hi <= frame_byte;
                     sub     <= 4'h1;
                  end else begin
                     sub   <= 4'h0;
                     state <= next_state;
                  end
               end
               S_TAG: begin
                  sub <= sub + 4'h1;
                  if (sub == 4'h1) begin
                     sub   <= 4'h0;
                     tags  <= tags + 2'd1;
                     state <= S_TYPE;
                  end
               end
               S_ITAG: begin
                  sub <= sub + 4'h1;
               end
               S_LLC: begin
                  // oui bytes then snap type in S_TYPE
                  sub <= sub + 4'h1;
                  if (llc_ok && (sub == `ENPH_LLC_LAST)) begin
                     sub      <= 4'h0;
                     llc_seen <= 1'b1;
                     state    <= S_TYPE;
                  end
               end
               S_WAIT: begin
                  if (frame_last) begin
                     state <= S_IDLE;
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
            // one load point, so every result path fills the same fields
            if (fire) begin
               res_valid      <= 1'b1;
               res_match      <= fire_hit;
               res_next_stage <= next_stage_pointer;
               res_offset     <= off + 6'd1;
               res_sig_offset <= signature_field_position;
               last_match     <= fire_hit;
               last_offset    <= off + 6'd1;
               state          <= frame_last ? S_IDLE : S_WAIT;
            end
         end
      end
   end

endmodule // enph_stage

/* File: enph_stage_properties.sv */
// Purpose : port checks of the next-protocol stage
// Assumes : bound to enph_stage from tb_top
// Notes   : byte count restarts on each marked byte zero
module enph_stage_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        frame_valid,
   input wire logic        frame_start,
   input wire logic        flow_hit,
   input wire logic        res_valid,
   input wire logic        res_match,
   input wire logic [5:0]  res_offset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] n_bytes;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_bytes <= 6'h0;
      end else if (frame_valid) begin
         n_bytes <= frame_start ? 6'h1 : n_bytes + 6'h1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_acc; pready |-> psel && penable && $past(psel && !penable); endproperty
   a_acc: assert property (p_acc) else $error("ready outside access");
   property p_unm; psel && !penable && paddr > 8'h0c |=>
      pslverr && ($past(pwrite) || prdata == 32'h0); endproperty
   a_unm: assert property (p_unm) else $error("unmapped access accepted");
   property p_sts; psel && !penable && pwrite && paddr == 8'h0c |=> pslverr; endproperty
   a_sts: assert property (p_sts) else $error("status write accepted");
   property p_ok; psel && !penable && paddr < 8'h0c && paddr[1:0] == 2'b00 |=>
      !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("error on mapped register");
   property p_hold; !res_valid |-> $stable(res_match) && $stable(res_offset); endproperty
   a_hold: assert property (p_hold) else $error("result moved without valid");
   property p_set; res_valid && res_match |-> res_offset inside {14, 18, 22, 26, 30}; endproperty
   a_set: assert property (p_set) else $error("offset not a header length");
   property p_cnt; res_valid && res_match |-> res_offset == n_bytes; endproperty
   a_cnt: assert property (p_cnt) else $error("offset differs from bytes taken");
   property p_flow; res_valid && res_match |-> $past(flow_hit); endproperty
   a_flow: assert property (p_flow) else $error("match without flow hit");
   c_hit: cover property (res_valid && res_match);
   c_miss: cover property (res_valid && !res_match);
   c_err: cover property (pslverr);
endmodule // enph_stage_properties

/* File: enph_tag_class.v */
// Purpose : classifies a 16-bit type/length field
// Assumes : field is presented whole, high byte first on the wire
// Notes   : purely combinational
`include "enph_defs.vh"

module enph_tag_class (
   input  wire [15:0] type_field,
   input  wire [15:0] service_tag_protocol_id,
   output wire        is_ctag,
   output wire        is_stag,
   output wire        is_itag,
   output wire        is_len
);

   assign is_ctag = (type_field == `ENPH_TPID_CTAG);
   // programmable tpid covers s-tags and b-tags alike
   assign is_stag = (type_field == service_tag_protocol_id);
   assign is_itag = (type_field == `ENPH_TPID_ITAG);
   assign is_len  = (type_field < `ENPH_LEN_LIMIT);

endmodule // enph_tag_class

/* File: tb_top.sv */
// Purpose : self-checking bench for the next-protocol stage
// Assumes : stage id zero, so backbone parsing exists
// Notes   : results compared with a queue-based parser model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        frame_valid, frame_start, frame_last, flow_hit, res_valid, res_match;
   logic [7:0]  frame_byte;
   logic [2:0]  res_next_stage, nxt;
   logic [5:0]  res_offset;
   logic [4:0]  res_sig_offset, sig;
   logic [14:0] rq[$];
   logic        tce, bbe, mode;
   logic [15:0] tpid;
   int          mismatches, n_compared, cyc;
   enph_stage #(.STAGE_ID(3'h0)) i_enph_stage (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_start(frame_start),
      .frame_last(frame_last), .frame_byte(frame_byte), .flow_hit(flow_hit),
      .res_valid(res_valid), .res_match(res_match), .res_next_stage(res_next_stage),
      .res_offset(res_offset), .res_sig_offset(res_sig_offset));
   enph_src_model i_enph_src_model (.pclk(pclk), .frame_valid(frame_valid),
      .frame_start(frame_start), .frame_last(frame_last), .frame_byte(frame_byte),
      .flow_hit(flow_hit));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // hang guard: far beyond the fewer than two thousand cycles the run needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (res_valid === 1'b1) rq.push_back({res_match, res_offset, res_next_stage, res_sig_offset});
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk("read data", e, rd & m);
      chk("slave error", {31'h0, ee}, {31'h0, er});
   endtask
   task automatic cfg(input logic t, input logic b, input logic md, input logic [2:0] nx,
                      input logic [4:0] sg);
      tce = t;
      bbe = b;
      mode = md;
      nxt = nx;
      sig = sg;
      apb(1'b1, 8'h00, {19'h0, sg, 1'b0, nx, 1'b0, md, b, t});
      rchk(8'h00, 32'h0000_1f77, {19'h0, sg, 1'b0, nx, 1'b0, md, b, t}, 1'b0);
   endtask
   task automatic model(input logic [7:0] f[$], output bit m, output int off);
      int p;
      int tags;
      bit llc;
      logic [15:0] t;
      p = 12;
      tags = 0;
      llc = 0;
      m = 0;
      off = 0;
      forever begin
         t = {f[p], f[p+1]};
         p = p + 2;
         if (bbe) begin
            if (t == tpid && tags == 0) begin
               tags = 1;
               p = p + 2;
               continue;
            end
            m = (t == 16'h88e7);
            off = p + 4;
            return;
         end
         if ((t == 16'h8100 || t == tpid) && tags < 2) begin
            tags++;
            p = p + 2;
         end else if (t < 16'h0600) begin
            if (!mode || llc || f[p] < 8'haa || f[p] > 8'hab || f[p+1] < 8'haa || f[p+1] > 8'hab
                || f[p+2] != 8'h03 || f[p+3] != 0 || f[p+4] != 0 || (f[p+5] != 0 && f[p+5] != 8'hf8))
               return;
            llc = 1;
            p = p + 6;
         end else begin
            m = !tce || llc || ((t ^ 16'h8800) & 16'hff00) == 0;
            off = p;
            return;
         end
      end
   endtask
   task automatic run(input logic [15:0] w[$], input bit slow, input bit hit);
      logic [7:0] f[$];
      logic [14:0] r;
      bit m;
      int off;
      int n;
      for (int i = 0; i < 12; i++) f.push_back(8'(rnd()));
      foreach (w[i]) f = {f, w[i][15:8], w[i][7:0]};
      f = {f, 8'h5a, 8'h3c};
      model(f, m, off);
      m = m & hit;
      i_enph_src_model.send(f, slow, hit);
      n = 0;
      while (rq.size() == 0 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
      chk("result count", 32'h1, rq.size());
      r = (rq.size() > 0) ? rq.pop_front() : 15'h0;
      chk("match", {31'h0, m}, {31'h0, r[14]});
      chk("next stage", {29'h0, nxt}, {29'h0, r[7:5]});
      chk("signature", {27'h0, sig}, {27'h0, r[4:0]});
      if (m) chk("offset", off, {26'h0, r[13:8]});
      rq.delete();
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      logic [15:0] w[$];
      int nt;
      seed = 32'h0000_e649;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      tpid = 16'h8a88;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(8'h00, 32'h0000_1f73, 32'h0000_0050, 1'b0);
      rchk(8'h04, 32'hffff_ffff, 32'hffff_0000, 1'b0);
      rchk(8'h08, 32'h0000_ffff, 32'h0000_8a88, 1'b0);
      rchk(8'h10, 32'hffff_ffff, 32'h0, 1'b1);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      chk("status write", 32'h1, {31'h0, er});
      apb(1'b1, 8'h04, 32'hff00_8800);
      cfg(1'b1, 1'b0, 1'b1, 3'h2, 5'h11);
      run('{16'h88f7}, 0, 1);
      run('{16'h0800}, 1, 1);
      run('{16'h88f7}, 0, 0);
      run('{16'h8100, 16'h0001, 16'h8a88, 16'h0002, 16'h8801}, 1, 1);
      run('{16'h002e, 16'haaab, 16'h0300, 16'h0000, 16'h0800}, 0, 1);
      run('{16'h002e, 16'habaa, 16'h0300, 16'h00f8, 16'h8100, 16'h0003, 16'h88f7}, 0, 1);
      run('{16'h8100, 16'h0001, 16'h8100, 16'h0002, 16'h002e, 16'haaaa, 16'h0300, 16'h0000,
            16'h88f7}, 0, 1);
      run('{16'h002e, 16'haaaa, 16'h0400, 16'h0000, 16'h88f7}, 0, 1);
      run('{16'h002e, 16'haaaa, 16'h0300, 16'h0100, 16'h88f7}, 0, 1);
      cfg(1'b1, 1'b0, 1'b0, 3'h4, 5'h1f);
      run('{16'h002e, 16'haaaa, 16'h0300, 16'h0000, 16'h88f7}, 1, 1);
      apb(1'b1, 8'h08, 32'h0000_9100);
      tpid = 16'h9100;
      run('{16'h9100, 16'h0005, 16'h88f7}, 1, 1);
      rchk(8'h0c, 32'h0000_3f03, 32'h0000_1201, 1'b0);
      run('{16'h8a88, 16'h0005, 16'h88f7}, 0, 1);
      cfg(1'b0, 1'b1, 1'b1, 3'h1, 5'h00);
      run('{16'h9100, 16'h0007, 16'h88e7, 16'h0000, 16'h0001, 16'h1111}, 0, 1);
      run('{16'h88e7, 16'h0000, 16'h0001}, 1, 1);
      run('{16'h8100, 16'h0007, 16'h88e7, 16'h0000, 16'h0001}, 0, 1);
      cfg(1'b0, 1'b0, 1'b1, 3'h5, 5'h0a);
      for (int k = 0; k < 24; k++) begin
         w.delete();
         nt = rnd() % 3;
         repeat (nt) w = {w, (rnd() % 2) ? 16'h8100 : 16'h9100, 16'(rnd() & 32'h0000_0fff)};
         w.push_back((rnd() % 2) ? 16'h88f7 : 16'((rnd() & 32'h0000_7fff) | 32'h0000_0800));
         run(w, rnd() % 2, rnd() % 2);
      end
      results();
   end
endmodule // tb_top
bind enph_stage enph_stage_properties i_enph_stage_properties (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_start(frame_start),
   .flow_hit(flow_hit), .res_valid(res_valid), .res_match(res_match), .res_offset(res_offset));
